// ### tac_calib_engine.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - fast fifo takes one conversion sequence in skip count plus one, so its period scales with the skip count.
// - slow filter enable opens the slow load path when the sample and slow word 1 differ past the threshold, no proximity.
// - first proximity is set when fast words 0 and 3 differ by more than the approach threshold.
// - second proximity is set when fast average and ambient differ by more than the hover threshold.
// - second comparator without the first marks an ambient shift left by the user.
// - a sample enters slow word 1 only with slow enable set and no proximity; slow word 0 takes every sample.
// - once enabled, compensation runs on every conversion of stages 0 through the last stage without host action.
// - trip levels are ambient plus or minus a sensitivity fraction of the upper and lower offsets.
// - the interrupt output rises when a sample goes beyond its positive or negative trip level.
// - offsets move by the ambient drift and trip levels are recomputed from the new offsets.
// - compensation setup sits in control registers at indices 2 through 6.
// - each stage keeps its calibration data and setup in on-chip memory.
// - a hover lasting the recalibration count of sequences forces the ambient to the fast average.
// - ambient tracking is frozen while proximity is detected, unless a forced recalibration fires.
module tac_calib_engine import tac_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tac_sample_t sample_in,
  output logic touch_int
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absdiff
  function automatic logic [15:0] pct(input logic [15:0] v, input logic [3:0] s);
    logic [19:0] p;
    p = {4'h0, v} * {16'h0000, s};
    return p[19:4];
  endfunction : pct
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge
  function automatic logic [15:0] get_field(input tac_stage_t s, input logic [3:0] f);
    logic [15:0] v;
    v = 16'h0000;
    unique case (f)
      4'h0: v = s.ff0;
      4'h1: v = s.ff1;
      4'h2: v = s.ff2;
      4'h3: v = s.ff3;
      4'h4: v = s.sf0;
      4'h5: v = s.sf1;
      4'h6: v = s.ambient;
      4'h7: v = s.off_high;
      4'h8: v = s.off_low;
      4'h9: v = s.high_thr;
      4'hA: v = s.low_thr;
      4'hB: v = {4'h0, s.prox2, s.prox1, s.recal_cnt};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : get_field
  function automatic tac_stage_t set_field(input tac_stage_t s, input logic [3:0] f, input logic [15:0] d);
    tac_stage_t r;
    r = s;
    unique case (f)
      4'h0: r.ff0 = d;
      4'h1: r.ff1 = d;
      4'h2: r.ff2 = d;
      4'h3: r.ff3 = d;
      4'h4: r.sf0 = d;
      4'h5: r.sf1 = d;
      4'h6: r.ambient = d;
      4'h7: r.off_high = d;
      4'h8: r.off_low = d;
      4'h9: r.high_thr = d;
      4'hA: r.low_thr = d;
      4'hB: {r.prox2, r.prox1, r.recal_cnt} = d[11:0];
      default: r = s;
    endcase
    return r;
  endfunction : set_field

  // ==========================================================
  // register bus decode
  logic [31:0] prox_ctrl_r, amb_ctrl_r, recal_ctrl_r, setup_r, sens_r, stg_sel_r, prdata_r;
  logic [15:0] active_r, shift_r;
  logic int_r;
  tac_state_t state_r, state_nxt;
  logic op_host_r, op_write_r, take_r;
  logic [3:0] stage_r;
  logic [15:0] sample_r;
  tac_sample_t samp_r;
  tac_stage_t rec_r, rec_nxt, rec_calc, cur;
  logic [187:0] ram_rdata;

  wire [7:0] idx = paddr[9:2];
  wire hit_prox = (idx == IDX_PROX_CTRL);
  wire hit_amb = (idx == IDX_AMB_CTRL);
  wire hit_recal = (idx == IDX_RECAL_CTRL);
  wire hit_setup = (idx == IDX_SETUP);
  wire hit_sens = (idx == IDX_SENS);
  wire hit_status = (idx == IDX_STATUS);
  wire hit_sel = (idx == IDX_STG_SEL);
  wire hit_data = (idx == IDX_STG_DATA);
  wire mapped = hit_prox | hit_amb | hit_recal | hit_setup | hit_sens | hit_status | hit_sel | hit_data;
  wire acc = psel & penable;
  wire host_done = (state_r == ST_STORE) & op_host_r;
  wire wr_ok = acc & pwrite & mapped & ~hit_data;
  wire [31:0] rd_mux = hit_prox ? prox_ctrl_r : hit_amb ? amb_ctrl_r : hit_recal ? recal_ctrl_r :
                       hit_setup ? setup_r : hit_sens ? sens_r : hit_sel ? stg_sel_r :
                       hit_status ? {shift_r, active_r} : 32'h0000_0000;
  assign pready = ~(acc & hit_data) | host_done;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_r;
  assign touch_int = int_r;
  // ==========================================================
  // control fields
  wire [3:0] skip_cnt = prox_ctrl_r[SKIP_LSB +: 4];
  wire [7:0] approach_thr = amb_ctrl_r[APPROACH_LSB +: 8];
  wire [5:0] hover_thr = amb_ctrl_r[HOVER_LSB +: 6];
  wire [9:0] fp_recal = recal_ctrl_r[FP_RECAL_LSB +: 10];
  wire [5:0] lp_recal = recal_ctrl_r[LP_RECAL_LSB +: 6];
  wire [3:0] last_stage = setup_r[LAST_STAGE_LSB +: 4];
  wire cal_en = setup_r[CAL_EN_BIT];
  wire lp_mode = setup_r[LP_MODE_BIT];
  wire [7:0] slow_thr = setup_r[SLOW_THR_LSB +: 8];
  wire [3:0] pos_sens = sens_r[POS_SENS_LSB +: 4];
  wire [3:0] neg_sens = sens_r[NEG_SENS_LSB +: 4];
  wire [3:0] sel_stage = stg_sel_r[SEL_STAGE_LSB +: 4];
  wire [3:0] sel_field = stg_sel_r[SEL_FIELD_LSB +: 4];
  wire [9:0] recal_timeout = lp_mode ? {4'h0, lp_recal} : fp_recal;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prox_ctrl_r <= RST_ZERO;
      amb_ctrl_r <= RST_ZERO;
      recal_ctrl_r <= RST_ZERO;
      setup_r <= RST_ZERO;
      sens_r <= RST_ZERO;
      stg_sel_r <= RST_ZERO;
    end else if (wr_ok) begin
      if (hit_prox) prox_ctrl_r <= merge(prox_ctrl_r, pwdata, pstrb) & MASK_PROX_CTRL;
      if (hit_amb) amb_ctrl_r <= merge(amb_ctrl_r, pwdata, pstrb) & MASK_AMB_CTRL;
      if (hit_recal) recal_ctrl_r <= merge(recal_ctrl_r, pwdata, pstrb) & MASK_RECAL_CTRL;
      if (hit_setup) setup_r <= merge(setup_r, pwdata, pstrb) & MASK_SETUP;
      if (hit_sens) sens_r <= merge(sens_r, pwdata, pstrb) & MASK_SENS;
      if (hit_sel) stg_sel_r <= merge(stg_sel_r, pwdata, pstrb) & MASK_STG_SEL;
    end
  end

  // ==========================================================
  // sample capture and sequencing
  wire take_samp = (state_r == ST_IDLE) & samp_r.valid;
  wire samp_ok = cal_en & (samp_r.stage <= last_stage);
  wire start_samp = take_samp & samp_ok;
  wire start_host = (state_r == ST_IDLE) & ~samp_r.valid & acc & hit_data;
  wire seq_done = (state_r == ST_STORE) & ~op_host_r & (stage_r == last_stage);
  wire fast_take;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_r <= '0;
    end else if (sample_in.valid) begin
      samp_r <= sample_in;
    end else if (take_samp) begin
      samp_r.valid <= 1'b0;
    end
  end
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (start_samp | start_host) state_nxt = ST_FETCH;
      ST_FETCH: state_nxt = ST_STORE;
      ST_STORE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      op_host_r <= 1'b0;
      op_write_r <= 1'b0;
      stage_r <= 4'h0;
      sample_r <= 16'h0000;
      take_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        op_host_r <= start_host;
        op_write_r <= pwrite;
        stage_r <= start_host ? sel_stage : samp_r.stage;
        sample_r <= samp_r.data;
        take_r <= fast_take;
      end
    end
  end
  tac_fast_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .seq_done(seq_done),
    .skip_count(skip_cnt),
    .take(fast_take)
  );
  tac_stage_ram #(.W(188), .AW(STG_AW)) u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .we(state_r == ST_STORE),
    .waddr(stage_r),
    .wdata(rec_r),
    .re(start_samp | start_host),
    .raddr(start_host ? sel_stage : samp_r.stage),
    .rdata(ram_rdata)
  );
  // ==========================================================
  // calibration datapath
  assign cur = tac_stage_t'(ram_rdata);
  wire [15:0] f0 = take_r ? sample_r : cur.ff0;
  wire [15:0] f1 = take_r ? cur.ff0 : cur.ff1;
  wire [15:0] f2 = take_r ? cur.ff1 : cur.ff2;
  wire [15:0] f3 = take_r ? cur.ff2 : cur.ff3;
  wire [17:0] fsum = {2'b00, f0} + {2'b00, f1} + {2'b00, f2} + {2'b00, f3};
  wire [15:0] avg = fsum[17:2];
  wire prox1 = absdiff(f0, f3) > {8'h00, approach_thr};
  wire prox2 = absdiff(avg, cur.ambient) > {10'h000, hover_thr};
  wire prox_any = prox1 | prox2;
  wire [9:0] cnt_inc = cur.recal_cnt + 10'h001;
  wire recal_fire = prox2 & (recal_timeout != 10'h000) & (cnt_inc >= recal_timeout);
  wire slow_en = (absdiff(sample_r, cur.sf1) > {8'h00, slow_thr}) & ~prox_any;
  wire [16:0] amb_sum = {1'b0, cur.ambient} + {1'b0, sample_r};
  wire [15:0] amb_new = recal_fire ? avg : slow_en ? amb_sum[16:1] : cur.ambient;
  wire [15:0] drift = amb_new - cur.ambient;
  wire [15:0] offh_new = cur.off_high - drift;
  wire [15:0] offl_new = cur.off_low + drift;
  wire trip = (sample_r > cur.high_thr) | (sample_r < cur.low_thr);

  always_comb begin
    rec_calc = cur;
    rec_calc.ff0 = f0;
    rec_calc.ff1 = f1;
    rec_calc.ff2 = f2;
    rec_calc.ff3 = f3;
    rec_calc.sf0 = sample_r;
    rec_calc.sf1 = recal_fire ? avg : slow_en ? sample_r : cur.sf1;
    rec_calc.ambient = amb_new;
    rec_calc.off_high = offh_new;
    rec_calc.off_low = offl_new;
    rec_calc.high_thr = amb_new + pct(offh_new, pos_sens);
    rec_calc.low_thr = amb_new - pct(offl_new, neg_sens);
    rec_calc.recal_cnt = (prox2 & ~recal_fire) ? cnt_inc : 10'h000;
    rec_calc.prox1 = prox1;
    rec_calc.prox2 = prox2 & ~recal_fire;
  end

  assign rec_nxt = op_host_r ? (op_write_r ? set_field(cur, sel_field, pwdata[15:0]) : cur) : rec_calc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_r <= '0;
    end else if (state_r == ST_FETCH) begin
      rec_r <= rec_nxt;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 16'h0000;
      shift_r <= 16'h0000;
      int_r <= 1'b0;
    end else begin
      int_r <= |active_r;
      if ((state_r == ST_FETCH) & ~op_host_r) begin
        active_r[stage_r] <= trip;
        shift_r[stage_r] <= prox2 & ~prox1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata_r <= rd_mux;
    end else if ((state_r == ST_FETCH) & op_host_r & ~op_write_r) begin
      prdata_r <= {16'h0000, get_field(cur, sel_field)};
    end
  end

  // ==========================================================
  // checks
  wire calc_cyc = (state_r == ST_FETCH) & ~op_host_r;
  AST_FAST_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc & take_r |=> (rec_r.ff1 == $past(cur.ff0)) && (rec_r.ff0 == $past(sample_r)))
    else $error("fast fifo did not shift");
  AST_SLOW_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc & prox_any & ~recal_fire |=> rec_r.sf1 == $past(cur.sf1))
    else $error("slow fifo loaded during proximity");
  AST_PROX1: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc & (absdiff(f0, f3) > {8'h00, approach_thr}) |=> rec_r.prox1)
    else $error("approach flag missing");
  AST_PROX2: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc & ~recal_fire & (absdiff(avg, cur.ambient) > {10'h000, hover_thr}) |=> rec_r.prox2)
    else $error("hover flag missing");
  AST_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc & prox2 & ~prox1 |=> shift_r[$past(stage_r)])
    else $error("ambient shift flag missing");
  AST_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE) & samp_r.valid & samp_ok |=> (state_r == ST_FETCH) ##1 (state_r == ST_STORE))
    else $error("conversion not processed");
  AST_INT: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc & trip |=> ##1 touch_int)
    else $error("interrupt not raised on trip");
  AST_RECAL: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc & recal_fire |=> (rec_r.ambient == $past(avg)) && !rec_r.prox2 && (rec_r.recal_cnt == 10'h000))
    else $error("forced recalibration missing");
  AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc & prox_any & ~recal_fire |=> rec_r.ambient == $past(cur.ambient))
    else $error("ambient moved during proximity");
  AST_OFFSET: assert property (@(posedge pclk) disable iff (!presetn)
    calc_cyc |=> (rec_r.off_high + rec_r.ambient) == ($past(cur.off_high) + $past(cur.ambient)))
    else $error("offset not moved by drift");
  AST_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_FETCH) |=> (state_r == ST_STORE) ##1 (state_r == ST_IDLE))
    else $error("stage memory not written back");
  AST_HOST_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    acc & hit_data & (state_r == ST_IDLE) & ~samp_r.valid |-> ##[1:2] pready)
    else $error("stage data access stalled");

endmodule : tac_calib_engine

// ### tac_pkg.sv
package tac_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_PROX_CTRL = 8'h02;
  localparam logic [7:0] IDX_AMB_CTRL = 8'h03;
  localparam logic [7:0] IDX_RECAL_CTRL = 8'h04;
  localparam logic [7:0] IDX_SETUP = 8'h05;
  localparam logic [7:0] IDX_SENS = 8'h06;
  localparam logic [7:0] IDX_STATUS = 8'h07;
  localparam logic [7:0] IDX_STG_SEL = 8'h08;
  localparam logic [7:0] IDX_STG_DATA = 8'h09;

  // ==========================================================
  // reset values and writable masks
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] MASK_PROX_CTRL = 32'h0000_0FFF;
  localparam logic [31:0] MASK_AMB_CTRL = 32'h0000_3FFF;
  localparam logic [31:0] MASK_RECAL_CTRL = 32'h0000_FFFF;
  localparam logic [31:0] MASK_SETUP = 32'h0000_FF3F;
  localparam logic [31:0] MASK_SENS = 32'h0000_00FF;
  localparam logic [31:0] MASK_STG_SEL = 32'h0000_0F0F;

  // ==========================================================
  // field positions
  localparam int SKIP_LSB = 0;
  localparam int APPROACH_LSB = 0;
  localparam int HOVER_LSB = 8;
  localparam int FP_RECAL_LSB = 0;
  localparam int LP_RECAL_LSB = 10;
  localparam int LAST_STAGE_LSB = 0;
  localparam int CAL_EN_BIT = 4;
  localparam int LP_MODE_BIT = 5;
  localparam int SLOW_THR_LSB = 8;
  localparam int POS_SENS_LSB = 0;
  localparam int NEG_SENS_LSB = 4;
  localparam int SEL_STAGE_LSB = 0;
  localparam int SEL_FIELD_LSB = 8;

  // ==========================================================
  // stage memory
  localparam int STAGES = 16;
  localparam int STG_AW = 4;

  typedef struct packed {
    logic [15:0] ff0;
    logic [15:0] ff1;
    logic [15:0] ff2;
    logic [15:0] ff3;
    logic [15:0] sf0;
    logic [15:0] sf1;
    logic [15:0] ambient;
    logic [15:0] off_high;
    logic [15:0] off_low;
    logic [15:0] high_thr;
    logic [15:0] low_thr;
    logic [9:0] recal_cnt;
    logic prox1;
    logic prox2;
  } tac_stage_t;

  typedef struct packed {
    logic valid;
    logic [3:0] stage;
    logic [15:0] data;
  } tac_sample_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_STORE = 2'b10
  } tac_state_t;

endpackage : tac_pkg

// ### tac_stage_ram.sv
`timescale 1ns/1ps
module tac_stage_ram #(
  parameter int W = 188,
  parameter int AW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : tac_stage_ram

// ### tac_fast_gate.sv
`timescale 1ns/1ps
module tac_fast_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic seq_done,
  input wire logic [3:0] skip_count,
  output logic take
);

  logic [3:0] cnt_r;

  // one sequence in skip_count+1 feeds the fast fifo
  assign take = (cnt_r == 4'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
    end else if (seq_done) begin
      cnt_r <= (cnt_r >= skip_count) ? 4'h0 : cnt_r + 4'h1;
    end
  end

endmodule : tac_fast_gate

// ### tac_conv_model.sv
`timescale 1ns/1ps
module tac_conv_model import tac_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic [3:0] stage,
  input wire logic [15:0] data,
  output tac_sample_t sample
);
  // ==========================================================
  // converter side: one-cycle valid pulse, data scrambled while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample <= '0;
    end else if (fire) begin
      sample <= '{valid: 1'b1, stage: stage, data: data};
    end else begin
      sample <= '{valid: 1'b0, stage: sample.stage, data: ~sample.data};
    end
  end
endmodule : tac_conv_model

// ### touch_ambient_calibration_tb.sv
`timescale 1ns/1ps
module touch_ambient_calibration_tb import tac_pkg::*;;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [9:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tac_sample_t sample;
  logic touch_int;
  logic fire;
  logic [3:0] st;
  logic [15:0] dat;
  int n_mismatch;
  int checks;
  int cycles;
  logic [7:0] idx_tab [6] = '{IDX_PROX_CTRL, IDX_AMB_CTRL, IDX_RECAL_CTRL, IDX_SETUP, IDX_SENS, IDX_STG_SEL};
  logic [31:0] mask_tab [6] = '{MASK_PROX_CTRL, MASK_AMB_CTRL, MASK_RECAL_CTRL, MASK_SETUP, MASK_SENS, MASK_STG_SEL};
  logic [15:0] init_tab [12] = '{16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8,
                                 16'h03E8, 16'h00A0, 16'h00A0, 16'h0438, 16'h0398, 16'h0000};
  logic [31:0] rd;
  logic err;

  // ==========================================================
  // design and converter
  tac_calib_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_in(sample), .touch_int(touch_int));
  tac_conv_model conv (.pclk(pclk), .presetn(presetn), .fire(fire), .stage(st), .data(dat), .sample(sample));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ==========================================================
  // reporting
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("MISMATCH timeout expected finish seen hang");
      stop_test();
    end
  end

  // ==========================================================
  // bus and converter tasks
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic erv);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", {31'h0, pready}, 32'h0000_0001);
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, rd, err);
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] idx, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    chk(name, rd & m, exp);
  endtask : rdc

  task automatic sfr(input string name, input logic [3:0] s, input logic [3:0] f, input logic [15:0] m,
                     input logic [15:0] exp);
    wr(IDX_STG_SEL, {20'h0_0000, f, 4'h0, s});
    rdc(name, IDX_STG_DATA, {16'h0000, m}, {16'h0000, exp});
  endtask : sfr

  task automatic send(input logic [3:0] s, input logic [15:0] d);
    @(posedge pclk);
    fire <= 1'b1;
    st <= s;
    dat <= d;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : send

  task automatic trip(input logic exp);
    rdc("trip flags", IDX_STATUS, 32'h0000_FFFF, {31'h0, exp});
    chk("touch_int", {31'h0, touch_int}, {31'h0, exp});
  endtask : trip

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    fire = 1'b0;
    st = '0;
    dat = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 2; i <= 8; i++) begin
      rdc("reset value", i[7:0], 32'hFFFF_FFFF, RST_ZERO);
    end
    for (int i = 0; i < 6; i++) begin
      wr(idx_tab[i], 32'hFFFF_FFFF);
      rdc("writable bits", idx_tab[i], 32'hFFFF_FFFF, mask_tab[i]);
    end
    wr(IDX_STATUS, 32'hFFFF_FFFF);
    rdc("status read only", IDX_STATUS, 32'hFFFF_FFFF, RST_ZERO);
    chk("mapped no error", {31'h0, err}, 32'h0000_0000);
    apb(1'b0, 8'h3F, 32'h0000_0000, rd, err);
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    chk("unmapped data", rd, RST_ZERO);
    // skip 0, approach 255, hover 63, no recal, sixteenths 8/8, slow level 10, calibration off
    wr(IDX_PROX_CTRL, 32'h0000_0000);
    wr(IDX_AMB_CTRL, 32'h0000_3FFF);
    wr(IDX_RECAL_CTRL, 32'h0000_0000);
    wr(IDX_SENS, 32'h0000_0088);
    wr(IDX_SETUP, 32'h0000_0A00);
    for (int f = 0; f < 12; f++) begin
      wr(IDX_STG_SEL, {20'h0_0000, f[3:0], 8'h00});
      wr(IDX_STG_DATA, {16'h0000, init_tab[f]});
    end
    sfr("stage high trip level", 4'h0, 4'h9, 16'hFFFF, 16'h0438);
    send(4'h0, 16'h0BB8);
    trip(1'b0);
    wr(IDX_SETUP, 32'h0000_0A10);
    send(4'h1, 16'h0BB8);
    trip(1'b0);
    // quiet drift of 50 codes moves ambient and offsets
    send(4'h0, 16'h041A);
    sfr("ambient", 4'h0, 4'h6, 16'hFFFF, 16'h0401);
    sfr("slow word 1", 4'h0, 4'h5, 16'hFFFF, 16'h041A);
    sfr("upper offset", 4'h0, 4'h7, 16'hFFFF, 16'h0087);
    sfr("lower offset", 4'h0, 4'h8, 16'hFFFF, 16'h00B9);
    sfr("positive trip level", 4'h0, 4'h9, 16'hFFFF, 16'h0444);
    sfr("negative trip level", 4'h0, 4'hA, 16'hFFFF, 16'h03A5);
    trip(1'b0);
    // sharp approach: both comparators fire, ambient frozen
    send(4'h0, 16'h0BB8);
    trip(1'b1);
    sfr("proximity flags", 4'h0, 4'hB, 16'h0C00, 16'h0C00);
    sfr("hover flag", 4'h0, 4'hB, 16'h0800, 16'h0800);
    sfr("ambient frozen", 4'h0, 4'h6, 16'hFFFF, 16'h0401);
    send(4'h0, 16'h0064);
    trip(1'b1);
    send(4'h0, 16'h0401);
    trip(1'b0);
    // hover without approach marks an ambient shift
    rdc("ambient shift flag", IDX_STATUS, 32'hFFFF_0000, 32'h0001_0000);
    // skip 1: two sequences shift the fast words once
    wr(IDX_PROX_CTRL, 32'h0000_0001);
    send(4'h0, 16'h0401);
    send(4'h0, 16'h0401);
    sfr("fast word 2", 4'h0, 4'h2, 16'hFFFF, 16'h0064);
    // full power timeout 1023 out of reach, then low power timeout 1 forces recal
    wr(IDX_RECAL_CTRL, 32'h0000_07FF);
    send(4'h0, 16'h0401);
    sfr("ambient before timeout", 4'h0, 4'h6, 16'hFFFF, 16'h0401);
    wr(IDX_SETUP, 32'h0000_0A30);
    send(4'h0, 16'h0401);
    sfr("recalibrated ambient", 4'h0, 4'h6, 16'hFFFF, 16'h0319);
    sfr("recal count and hover", 4'h0, 4'hB, 16'h0BFF, 16'h0000);
    stop_test();
  end
endmodule : touch_ambient_calibration_tb
